// file: core/acsc_channel.sv
// async / isochronous character channel with apb registers
// How it works
// - start bit, 5..8 data bits lsb first, optional parity, one or two stops
// - parity bit even, odd, or forced mark or space
// - oversampled reception expects rate 16, suitable clock mode, nrz line
// - receiver verifies start bit, samples known bit count, resyncs per character
// - each oversampled bit decided by majority of three centre samples
// - isochronous mode samples each bit exactly once
// - enabled receiver stores characters lsb first, optionally gated by carrier
// - length, stops and parity checked; parity storage can be suppressed
// - framing and parity errors flagged; per-character status stored optionally
// - fifo filling steered by threshold and optional termination character
// - optional time-out after a programmable idle time since last character
// - transmitter frames characters, flags all sent, then idles at one
// - transmitter same in both modes; rate only divides; cts may gate
// - break command forces txd low next edge, released edge after clear
// - all-zero frame is break: not stored, break flagged, end flagged
// - flow characters compared over char length with masks reset to zero
// - flow character needs framing, masked match and parity; flags event
// - recognised flow characters stored unless discard setting is one
// - xoff stops after current char, xon resumes; enable toggles force xon
// - fifo characters go only with xon and, when cts gating is on, cts low; status shows state
// - immediate char sent when idle or after current, even in xoff
// - pending flag from acceptance until immediate char is fully sent
`include "acsc_params.svh"

module acsc_channel #(
  parameter int unsigned TIMEOUT_WIDTH = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire acsc_pkg::acsc_apb_req_type apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // line pins
  input wire logic rxd_pin,
  input wire logic cts_n_pin,
  input wire logic carrier_detect_pin,
  output logic txd_pin,
  // transmit stream from the dma side
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // receive stream to the dma side
  output acsc_pkg::acsc_rx_word_type rx_word,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [4:0] rx_fifo_threshold
);

  // the counter limit is cut from the 16-bit time-out register
  if (TIMEOUT_WIDTH < 1 || TIMEOUT_WIDTH > 16)
  begin : gen_width_check
    $error("TIMEOUT_WIDTH out of range");
  end

  // mask of the significant bits for a length code
  function automatic logic [7:0] len_mask(input logic [1:0] code);
    len_mask = 8'hFF >> (3'd3 - {1'b0, code});
  endfunction

  // expected parity bit for the masked data
  function automatic logic parity_of(input logic [7:0] d, input logic [1:0] code,
                                     input logic [1:0] mode);
    logic ones;
    ones = ^(d & len_mask(code));
    unique case (mode)
      2'b00: parity_of = ones;
      2'b01: parity_of = ~ones;
      2'b10: parity_of = 1'b0;
      2'b11: parity_of = 1'b1;
    endcase
  endfunction

  // registers
  logic [`ACSC_CFG_WIDTH-1:0] config_reg;
  logic [15:0] baud_reg;
  logic [31:0] flow_reg;
  logic [12:0] term_reg;
  logic [15:0] timeout_reg;
  logic [7:0] imm_reg;
  logic imm_pend_reg;
  logic [`ACSC_EV_WIDTH-1:0] events_reg;
  logic xoff_reg;

  // config fields
  wire [1:0] len_code = config_reg[`ACSC_CFG_LEN_LSB +: 2];
  wire par_en = config_reg[`ACSC_CFG_PAR_EN];
  wire [1:0] pmode = config_reg[`ACSC_CFG_PMODE_LSB +: 2];
  wire two_stop = config_reg[`ACSC_CFG_TWO_STOP];
  wire rate16 = config_reg[`ACSC_CFG_RATE16];
  wire flow_en = config_reg[`ACSC_CFG_FLOW_EN];
  wire [7:0] lmask = len_mask(len_code);
  wire [3:0] data_bits = 4'd5 + {2'b00, len_code};
  wire [3:0] frame_bits = data_bits + {3'b000, par_en} + {3'b000, two_stop} + 4'd2;

  // apb decode
  wire apb_access = apb_req.psel & apb_req.penable;
  wire apb_wr = apb_access & apb_req.pwrite;
  wire [7:0] addr = apb_req.paddr;
  wire hit_cfg = addr == `ACSC_OFS_CONFIG;
  wire hit_baud = addr == `ACSC_OFS_BAUD;
  wire hit_flow = addr == `ACSC_OFS_FLOW;
  wire hit_term = addr == `ACSC_OFS_TERM;
  wire hit_tmo = addr == `ACSC_OFS_TIMEOUT;
  wire hit_imm = addr == `ACSC_OFS_IMM;
  wire hit_stat = addr == `ACSC_OFS_STATUS;
  wire hit_ev = addr == `ACSC_OFS_EVENTS;
  wire hit_any = hit_cfg | hit_baud | hit_flow | hit_term | hit_tmo | hit_imm | hit_stat | hit_ev;

  // pin synchronisers: {carrier, cts_n, rxd}; a change counts once stages 2 and 3 agree
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  logic [2:0] pins_reg;
  wire [2:0] agree = sync2_reg ~^ sync3_reg;
  wire [2:0] pins_next = (agree & sync3_reg) | (~agree & pins_reg);
  wire rxd_s = pins_reg[0];
  wire cts_ok = ~config_reg[`ACSC_CFG_CTS_GATE] | ~pins_reg[1];
  wire carrier_ok = ~config_reg[`ACSC_CFG_CARRIER_GATE] | pins_reg[2];
  wire rx_on = config_reg[`ACSC_CFG_RX_EN] & carrier_ok;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= 3'h3;
      sync2_reg <= 3'h3;
      sync3_reg <= 3'h3;
      pins_reg <= 3'h3;
    end
    else
    begin
      sync1_reg <= {carrier_detect_pin, cts_n_pin, rxd_pin};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pins_reg <= pins_next;
    end
  end

  // baud divider: one tick every baud_reg+1 clocks
  logic [15:0] div_reg;
  wire tick = div_reg == 16'h0000;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_reg <= 16'h0000;
    else
      div_reg <= tick ? baud_reg : div_reg - 16'h0001;
  end

  // receiver
  acsc_pkg::acsc_rx_state_type rx_state_reg;
  acsc_pkg::acsc_rx_state_type rx_state_next;
  logic [3:0] rx_phase_reg;
  logic [3:0] rx_idx_reg;
  logic [1:0] votes_reg;
  logic [7:0] rx_data_reg;
  logic rx_par_reg;
  logic rx_stop_bad_reg;
  logic rx_anyone_reg;
  logic [TIMEOUT_WIDTH+3:0] idle_cnt_reg;
  logic idle_fired_reg;

  wire maj = (votes_reg[0] & votes_reg[1]) | (votes_reg[0] & rxd_s) | (votes_reg[1] & rxd_s);
  wire rx_bit = rate16 ? maj : rxd_s;
  wire decide = (rx_state_reg == acsc_pkg::RX_BITS) & tick &
                (~rate16 | rx_phase_reg == `ACSC_VOTE_C);
  wire is_data = rx_idx_reg != 4'd0 && rx_idx_reg <= data_bits;
  wire is_par = par_en && rx_idx_reg == data_bits + 4'd1;
  wire is_last = rx_idx_reg == frame_bits - 4'd1;
  wire [2:0] dpos = 3'(rx_idx_reg - 4'd1);
  wire rx_done = decide & is_last;
  wire [7:0] rx_data_m = rx_data_reg & lmask;

  // frame checks at completion
  wire framing_bad = rx_stop_bad_reg | ~rx_bit;
  wire parity_bad = par_en & (rx_par_reg != parity_of(rx_data_reg, len_code, pmode));
  wire zero_frame = ~rx_anyone_reg & ~rx_bit;
  wire good_frame = ~framing_bad & ~parity_bad;
  wire [7:0] xon_cm = lmask & ~flow_reg[23:16];
  wire [7:0] xoff_cm = lmask & ~flow_reg[31:24];
  wire is_xon = good_frame & (((rx_data_m ^ flow_reg[7:0]) & xon_cm) == 8'h00);
  wire is_xoff = good_frame & (((rx_data_m ^ flow_reg[15:8]) & xoff_cm) == 8'h00);
  wire discard = config_reg[`ACSC_CFG_DISCARD] & (is_xon | is_xoff);
  wire store = rx_done & ~zero_frame & ~discard;
  wire term_hit = config_reg[`ACSC_CFG_TERM_EN] & (rx_data_m == (term_reg[7:0] & lmask));
  wire [8:0] par_field = {1'b0, rx_par_reg & par_en & ~config_reg[`ACSC_CFG_NO_PSTORE]};
  wire [8:0] stored_data = {1'b0, rx_data_m} | (par_field << data_bits);
  wire err_fmt = config_reg[`ACSC_CFG_ERR_FMT];

  // receive sequencing
  always_comb
  begin
    rx_state_next = rx_state_reg;
    unique case (rx_state_reg)
      acsc_pkg::RX_IDLE:
        if (rx_on && tick && !rxd_s)
          rx_state_next = acsc_pkg::RX_BITS;
      acsc_pkg::RX_BITS:
        if (decide && ((rx_idx_reg == 4'd0 && rx_bit) || is_last))
          rx_state_next = (is_last && zero_frame) ? acsc_pkg::RX_BREAK : acsc_pkg::RX_IDLE;
      acsc_pkg::RX_BREAK:
        if (rxd_s)
          rx_state_next = acsc_pkg::RX_IDLE;
      default:
        rx_state_next = acsc_pkg::RX_IDLE;
    endcase
    if (!rx_on && rx_state_reg == acsc_pkg::RX_BITS)
      rx_state_next = acsc_pkg::RX_IDLE;
  end

  // start in iso mode is taken on the detecting tick, so index begins at one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state_reg <= acsc_pkg::RX_IDLE;
      rx_phase_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      votes_reg <= 2'b11;
      rx_data_reg <= 8'h00;
      rx_par_reg <= 1'b0;
      rx_stop_bad_reg <= 1'b0;
      rx_anyone_reg <= 1'b0;
    end
    else
    begin
      rx_state_reg <= rx_state_next;
      if (rx_state_reg == acsc_pkg::RX_IDLE)
      begin
        rx_phase_reg <= 4'h1;
        rx_idx_reg <= rate16 ? 4'd0 : 4'd1;
        rx_stop_bad_reg <= 1'b0;
        rx_anyone_reg <= 1'b0;
        rx_data_reg <= 8'h00;
      end
      else if (rx_state_reg == acsc_pkg::RX_BITS && tick)
      begin
        rx_phase_reg <= rx_phase_reg + 4'h1;
        if (rx_phase_reg == `ACSC_VOTE_A || rx_phase_reg == `ACSC_VOTE_B)
          votes_reg <= {votes_reg[0], rxd_s};
        if (~rate16 || rx_phase_reg == `ACSC_OVS_LAST)
          rx_idx_reg <= rx_idx_reg + 4'd1;
      end
      if (decide)
      begin
        rx_anyone_reg <= rx_anyone_reg | rx_bit;
        if (is_data)
          rx_data_reg[dpos] <= rx_bit;
        else if (is_par)
          rx_par_reg <= rx_bit;
        else if (rx_idx_reg != 4'd0)
          rx_stop_bad_reg <= rx_stop_bad_reg | ~rx_bit;
      end
    end
  end

  // receive holding word towards the fifo
  logic rx_valid_reg;
  acsc_pkg::acsc_rx_word_type rx_word_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_valid_reg <= 1'b0;
      rx_word_reg <= '0;
    end
    else
    begin
      if (store)
      begin
        rx_valid_reg <= 1'b1;
        rx_word_reg <= {term_hit, framing_bad & err_fmt, parity_bad & err_fmt, stored_data};
      end
      else if (rx_ready)
        rx_valid_reg <= 1'b0;
    end
  end

  // idle time-out counted in bit periods since the last character
  wire [TIMEOUT_WIDTH+3:0] tmo_limit = rate16 ?
    {timeout_reg[TIMEOUT_WIDTH-1:0], 4'h0} : {4'h0, timeout_reg[TIMEOUT_WIDTH-1:0]};
  wire tmo_hit = tick & ~idle_fired_reg & (timeout_reg != 16'h0000) & (idle_cnt_reg == tmo_limit);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idle_cnt_reg <= '0;
      idle_fired_reg <= 1'b1;
    end
    else if (rx_done)
    begin
      idle_cnt_reg <= '0;
      idle_fired_reg <= 1'b0;
    end
    else if (tmo_hit)
      idle_fired_reg <= 1'b1;
    else if (tick && !idle_fired_reg)
      idle_cnt_reg <= idle_cnt_reg + 1'b1;
  end

  // transmitter
  acsc_pkg::acsc_tx_state_type tx_state_reg;
  logic [11:0] tx_shift_reg;
  logic [3:0] tx_left_reg;
  logic [3:0] tx_phase_reg;
  logic tx_imm_reg;
  logic txd_reg;

  wire tx_bit_end = (tx_state_reg == acsc_pkg::TX_SHIFT) & tick &
                    (~rate16 | tx_phase_reg == `ACSC_OVS_LAST);
  wire tx_last = tx_bit_end & (tx_left_reg == 4'd1);
  wire tx_free = (tx_state_reg == acsc_pkg::TX_IDLE) | tx_last;
  wire load_imm = tx_free & imm_pend_reg & ~(tx_last & tx_imm_reg) & cts_ok;
  wire load_fifo = tx_free & ~load_imm & tx_valid & cts_ok & ~xoff_reg;
  wire [7:0] load_data = load_imm ? imm_reg : tx_data;
  wire [7:0] load_m = load_data & lmask;
  wire load_par = parity_of(load_data, len_code, pmode);
  // data sits above the start bit; parity and stops are ones unless placed
  wire [11:0] frame_par = {11'h7FF, load_par} << (data_bits + 4'd1);
  wire [11:0] frame_word = {3'b111, load_m | ~lmask, 1'b0} &
                           (par_en ? frame_par | ~(12'h001 << (data_bits + 4'd1)) : 12'hFFF);

  assign tx_ready = load_fifo;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state_reg <= acsc_pkg::TX_IDLE;
      tx_shift_reg <= 12'hFFF;
      tx_left_reg <= 4'h0;
      tx_phase_reg <= 4'h0;
      tx_imm_reg <= 1'b0;
      txd_reg <= 1'b1;
    end
    else
    begin
      if (load_imm || load_fifo)
      begin
        tx_state_reg <= acsc_pkg::TX_SHIFT;
        tx_shift_reg <= frame_word;
        tx_left_reg <= frame_bits;
        tx_phase_reg <= 4'h0;
        tx_imm_reg <= load_imm;
      end
      else if (tx_last)
      begin
        tx_state_reg <= acsc_pkg::TX_IDLE;
        tx_shift_reg <= 12'hFFF;
        tx_imm_reg <= 1'b0;
      end
      else if (tx_state_reg == acsc_pkg::TX_SHIFT && tick)
      begin
        tx_phase_reg <= tx_phase_reg + 4'h1;
        if (tx_bit_end)
        begin
          tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
          tx_left_reg <= tx_left_reg - 4'd1;
        end
      end
      // break is one edge behind the command register in both directions
      txd_reg <= config_reg[`ACSC_CFG_BREAK] ? 1'b0 : tx_shift_reg[0];
    end
  end

  assign txd_pin = txd_reg;

  // events set by hardware; a write of one clears, a set in the same cycle wins
  wire [`ACSC_EV_WIDTH-1:0] ev_set;
  assign ev_set[`ACSC_EV_ALL_SENT] = tx_last & ~load_imm & ~load_fifo & ~tx_valid;
  assign ev_set[`ACSC_EV_BREAK] = rx_done & zero_frame;
  assign ev_set[`ACSC_EV_BREAK_END] = (rx_state_reg == acsc_pkg::RX_BREAK) & rxd_s;
  assign ev_set[`ACSC_EV_FRAMING] = rx_done & ~zero_frame & framing_bad;
  assign ev_set[`ACSC_EV_PARITY] = rx_done & ~zero_frame & parity_bad;
  assign ev_set[`ACSC_EV_XON] = rx_done & is_xon;
  assign ev_set[`ACSC_EV_XOFF] = rx_done & is_xoff;
  assign ev_set[`ACSC_EV_TIMEOUT] = tmo_hit;
  assign ev_set[`ACSC_EV_TERM] = store & term_hit;
  assign ev_set[`ACSC_EV_OVERRUN] = store & rx_valid_reg & ~rx_ready;
  wire [`ACSC_EV_WIDTH-1:0] ev_clr = (apb_wr & hit_ev) ?
    apb_req.pwdata[`ACSC_EV_WIDTH-1:0] : '0;

  wire cfg_wr = apb_wr & hit_cfg;
  wire flow_toggle = cfg_wr & (apb_req.pwdata[`ACSC_CFG_FLOW_EN] != flow_en);

  // register writes and side effects
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      config_reg <= `ACSC_RST_CONFIG;
      baud_reg <= `ACSC_RST_BAUD;
      flow_reg <= `ACSC_RST_FLOW;
      term_reg <= `ACSC_RST_TERM;
      timeout_reg <= `ACSC_RST_TIMEOUT;
      imm_reg <= 8'h00;
      imm_pend_reg <= 1'b0;
      events_reg <= '0;
      xoff_reg <= 1'b0;
    end
    else
    begin
      if (cfg_wr)
        config_reg <= apb_req.pwdata[`ACSC_CFG_WIDTH-1:0];
      if (apb_wr && hit_baud)
        baud_reg <= apb_req.pwdata[15:0];
      if (apb_wr && hit_flow)
        flow_reg <= apb_req.pwdata;
      if (apb_wr && hit_term)
        term_reg <= apb_req.pwdata[12:0];
      if (apb_wr && hit_tmo)
        timeout_reg <= apb_req.pwdata[15:0];
      // a rewrite while pending is dropped so the queued character stays intact
      if (apb_wr && hit_imm && !imm_pend_reg)
      begin
        imm_reg <= apb_req.pwdata[7:0];
        imm_pend_reg <= 1'b1;
      end
      else if (tx_last && tx_imm_reg)
        imm_pend_reg <= 1'b0;
      events_reg <= (events_reg & ~ev_clr) | ev_set;
      // toggling the enable either way lands in xon
      if (flow_toggle)
        xoff_reg <= 1'b0;
      else if (flow_en && rx_done && is_xoff)
        xoff_reg <= 1'b1;
      else if (flow_en && rx_done && is_xon)
        xoff_reg <= 1'b0;
    end
  end

  // read mux, zero-wait; unmapped addresses answer with an error and zero data
  wire [31:0] status_word = {27'h0, rx_valid_reg, rx_state_reg == acsc_pkg::RX_BREAK,
                             tx_state_reg == acsc_pkg::TX_SHIFT, imm_pend_reg, xoff_reg};
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (apb_req.psel && !apb_req.pwrite)
    begin
      if (hit_cfg)
        prdata = {16'h0000, config_reg};
      else if (hit_baud)
        prdata = {16'h0000, baud_reg};
      else if (hit_flow)
        prdata = flow_reg;
      else if (hit_term)
        prdata = {19'h0, term_reg};
      else if (hit_tmo)
        prdata = {16'h0000, timeout_reg};
      else if (hit_imm)
        prdata = {24'h0, imm_reg};
      else if (hit_stat)
        prdata = status_word;
      else if (hit_ev)
        prdata = {22'h0, events_reg};
    end
  end

  assign pready = 1'b1;
  assign pslverr = apb_access & ~hit_any;
  assign rx_valid = rx_valid_reg;
  assign rx_word = rx_word_reg;
  assign rx_fifo_threshold = term_reg[12:8];

endmodule

// file: pkg/acsc_params.svh
// register offsets, field positions, reset values and timing constants of the async channel
`ifndef ACSC_PARAMS_SVH
`define ACSC_PARAMS_SVH

// register byte offsets
`define ACSC_OFS_CONFIG 8'h00
`define ACSC_OFS_BAUD 8'h04
`define ACSC_OFS_FLOW 8'h08
`define ACSC_OFS_TERM 8'h0C
`define ACSC_OFS_TIMEOUT 8'h10
`define ACSC_OFS_IMM 8'h14
`define ACSC_OFS_STATUS 8'h18
`define ACSC_OFS_EVENTS 8'h1C

// config field positions
`define ACSC_CFG_LEN_LSB 0
`define ACSC_CFG_PAR_EN 2
`define ACSC_CFG_PMODE_LSB 3
`define ACSC_CFG_TWO_STOP 5
`define ACSC_CFG_RATE16 6
`define ACSC_CFG_RX_EN 7
`define ACSC_CFG_CARRIER_GATE 8
`define ACSC_CFG_CTS_GATE 9
`define ACSC_CFG_BREAK 10
`define ACSC_CFG_FLOW_EN 11
`define ACSC_CFG_DISCARD 12
`define ACSC_CFG_NO_PSTORE 13
`define ACSC_CFG_ERR_FMT 14
`define ACSC_CFG_TERM_EN 15
`define ACSC_CFG_WIDTH 16

// reset values
`define ACSC_RST_CONFIG 16'h0043
`define ACSC_RST_BAUD 16'h0000
`define ACSC_RST_FLOW 32'h0000_0000
`define ACSC_RST_TERM 13'h0000
`define ACSC_RST_TIMEOUT 16'h0000

// status and event bit positions
`define ACSC_ST_FLOW 0
`define ACSC_ST_IMM_PEND 1
`define ACSC_ST_TX_BUSY 2
`define ACSC_ST_BREAK 3
`define ACSC_ST_RX_VALID 4
`define ACSC_EV_ALL_SENT 0
`define ACSC_EV_BREAK 1
`define ACSC_EV_BREAK_END 2
`define ACSC_EV_FRAMING 3
`define ACSC_EV_PARITY 4
`define ACSC_EV_XON 5
`define ACSC_EV_XOFF 6
`define ACSC_EV_TIMEOUT 7
`define ACSC_EV_TERM 8
`define ACSC_EV_OVERRUN 9
`define ACSC_EV_WIDTH 10

// oversampling: ticks per bit and the three vote positions
`define ACSC_OVS_LAST 4'hF
`define ACSC_VOTE_A 4'h7
`define ACSC_VOTE_B 4'h8
`define ACSC_VOTE_C 4'h9
`define ACSC_OVS_SHIFT 4

`endif

// file: pkg/acsc_pkg.sv
// types shared by the async character channel
package acsc_pkg;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_BITS = 2'b01,
    RX_BREAK = 2'b10
  } acsc_rx_state_type;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SHIFT = 1'b1
  } acsc_tx_state_type;

  // one received character as handed to the receive fifo
  typedef struct packed {
    logic term_hit;
    logic framing_err;
    logic parity_err;
    logic [8:0] data;
  } acsc_rx_word_type;

  // apb slave request
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } acsc_apb_req_type;

endpackage

// file: test/acsc_channel_tb.sv
// self-checking bench for the async character channel
`include "acsc_params.svh"
module acsc_channel_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, pready, pslverr, rxd_pin, cts_n_pin, carrier_detect_pin, txd_pin;
  acsc_pkg::acsc_apb_req_type apb_req;
  acsc_pkg::acsc_rx_word_type rx_word;
  logic [31:0] prdata, rd;
  logic [7:0] tx_data, send_char, heard;
  logic [4:0] rx_fifo_threshold;
  logic tx_valid, tx_ready, rx_valid, rx_ready, send, stop_bit, heard_done, err;
  int fails, tests_run, n;
  acsc_channel acsc_channel_inst (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd_pin(rxd_pin), .cts_n_pin(cts_n_pin),
    .carrier_detect_pin(carrier_detect_pin), .txd_pin(txd_pin), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_fifo_threshold(rx_fifo_threshold)
  );
  acsc_remote acsc_remote_inst (
    .pclk(pclk), .send(send), .send_char(send_char), .stop_bit(stop_bit), .heard(heard),
    .heard_done(heard_done), .txd_pin(txd_pin), .rxd_pin(rxd_pin)
  );
  // 200 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // setup then access, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb_req <= '0;
    @(posedge pclk);
  endtask
  // level valid until the channel takes it; returns cycles waited
  task automatic push(input logic [7:0] c, output int w);
    w = 0;
    tx_data <= c;
    tx_valid <= 1'b1;
    do
    begin
      @(posedge pclk);
      w++;
    end
    while (tx_ready !== 1'b1 && w < 3000);
    tx_valid <= 1'b0;
    check("tx taken", 32'(w < 3000), 32'h1);
  endtask
  task automatic hear(input logic [7:0] c);
    logic old;
    int k;
    old = heard_done;
    for (k = 0; heard_done === old && k < 400; k++)
      @(posedge pclk);
    check("txd frame", 32'(heard_done !== old), 32'h1);
    check("txd char", 32'(heard), 32'(c));
  endtask
  // gap first so the remote has finished any earlier frame
  task automatic remote(input logic [7:0] c, input logic s);
    repeat (20) @(posedge pclk);
    send_char <= c;
    stop_bit <= s;
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
  endtask
  task automatic take_rx(input logic [11:0] c);
    int k;
    for (k = 0; rx_valid !== 1'b1 && k < 400; k++)
      @(posedge pclk);
    check("rx arrived", 32'(k < 400), 32'h1);
    check("rx word", 32'(rx_word), 32'(c));
    rx_ready <= 1'b1;
    @(posedge pclk);
    rx_ready <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // a whole run needs about 1600 cycles
  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    end_of_test;
  end
  initial
  begin
    {presetn, tx_valid, rx_ready, send, err} = 5'h00;
    {cts_n_pin, carrier_detect_pin, stop_bit} = 3'h7;
    apb_req = '0;
    tx_data = 8'h00;
    send_char = 8'h00;
    {fails, tests_run, n} = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("txd idle", 32'(txd_pin), 32'h1);
    apb(1'b0, `ACSC_OFS_CONFIG, 32'h0);
    check("config reset", rd, 32'h0000_0043);
    apb(1'b0, `ACSC_OFS_FLOW, 32'h0);
    check("mask reset", rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped", 32'(err), 32'h1);
    apb(1'b1, `ACSC_OFS_TERM, 32'h0000_1A00);
    check("threshold", 32'(rx_fifo_threshold), 32'h1A);
    $display("test reset done");
    apb(1'b1, `ACSC_OFS_FLOW, 32'h0000_1311);
    apb(1'b1, `ACSC_OFS_CONFIG, 32'h0000_02C3);
    fork
      push(8'hA5, n);
      begin
        repeat (40) @(posedge pclk);
        cts_n_pin <= 1'b0;
      end
    join
    check("cts hold", 32'(n >= 30), 32'h1);
    hear(8'hA5);
    repeat (20) @(posedge pclk);
    apb(1'b0, `ACSC_OFS_EVENTS, 32'h0);
    check("all sent", 32'(rd[0]), 32'h1);
    $display("test transmit done");
    remote(8'h3C, 1'b1);
    take_rx(12'h03C);
    remote(8'h00, 1'b0);
    repeat (250) @(posedge pclk);
    check("break kept out", 32'(rx_valid), 32'h0);
    apb(1'b0, `ACSC_OFS_EVENTS, 32'h0);
    check("break events", 32'(rd[2:1]), 32'h3);
    apb(1'b1, `ACSC_OFS_CONFIG, 32'h0000_42C6);
    remote(8'h83, 1'b1);
    take_rx(12'h283);
    apb(1'b0, `ACSC_OFS_EVENTS, 32'h0);
    check("parity event", 32'(rd[4:3]), 32'h2);
    $display("test receive done");
    apb(1'b1, `ACSC_OFS_CONFIG, 32'h0000_0AC3);
    remote(8'h13, 1'b1);
    take_rx(12'h013);
    fork
      push(8'h7E, n);
      begin
        apb(1'b1, `ACSC_OFS_IMM, 32'h0000_0055);
        apb(1'b0, `ACSC_OFS_STATUS, 32'h0);
        check("xoff pending", 32'(rd[1:0]), 32'h3);
        hear(8'h55);
        repeat (16) @(posedge pclk);
        apb(1'b0, `ACSC_OFS_STATUS, 32'h0);
        check("pending clear", 32'(rd[1]), 32'h0);
        remote(8'h11, 1'b1);
        take_rx(12'h011);
      end
    join
    check("held in xoff", 32'(n > 200), 32'h1);
    hear(8'h7E);
    $display("test flow done");
    apb(1'b1, `ACSC_OFS_CONFIG, 32'h0000_06C3);
    repeat (2) @(posedge pclk);
    check("break low", 32'(txd_pin), 32'h0);
    apb(1'b1, `ACSC_OFS_CONFIG, 32'h0000_02C3);
    repeat (2) @(posedge pclk);
    check("break off", 32'(txd_pin), 32'h1);
    $display("test break done");
    end_of_test;
  end
endmodule

// file: test/acsc_chk_sva.sv
// port assertions for the async channel
`include "acsc_params.svh"
module acsc_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire acsc_pkg::acsc_apb_req_type apb_req,
  input wire logic pready,
  input wire logic pslverr,
  // line and streams
  input wire logic cts_n_pin,
  input wire logic txd_pin,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic rx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cfg_q;
  wire acc = apb_req.psel && apb_req.penable;
  wire cfg_wr = acc && apb_req.pwrite && apb_req.paddr == `ACSC_OFS_CONFIG;
  wire bad = apb_req.paddr[1:0] != 2'h0 || apb_req.paddr > `ACSC_OFS_EVENTS;
  // mirror of the config word so break, rate and cts gating are known
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cfg_q <= `ACSC_RST_CONFIG;
    else if (cfg_wr)
      cfg_q <= apb_req.pwdata[15:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  zero_wait_a: assert property (acc |-> pready) else $error("access not ready");
  unmapped_err_a: assert property (acc && bad |-> pslverr) else $error("no slave error");
  mapped_ok_a: assert property (acc && !bad |-> !pslverr) else $error("stray slave error");
  idle_err_a: assert property (!acc |-> !pslverr) else $error("error outside access");
  break_low_a: assert property (cfg_q[10] && $past(cfg_q[10]) |-> !txd_pin)
    else $error("txd high during break");
  start_bit_a: assert property (tx_ready && cfg_q[6] |-> ##2 !txd_pin [*8])
    else $error("start bit missing");
  take_valid_a: assert property (tx_ready |-> tx_valid) else $error("take without valid");
  cts_gate_a: assert property ((cfg_q[9] && cts_n_pin) [*8] |-> !tx_ready)
    else $error("load while cts high");
  rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid) else $error("rx dropped");
  rx_pop_a: assert property (rx_valid && rx_ready |=> !rx_valid) else $error("rx not popped");
endmodule
bind acsc_channel acsc_chk acsc_chk_inst (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .pready(pready), .pslverr(pslverr),
  .cts_n_pin(cts_n_pin), .txd_pin(txd_pin), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .rx_valid(rx_valid), .rx_ready(rx_ready)
);

// file: test/acsc_remote.sv
// behavioural remote station: 8n1 sender on rxd, 8-bit listener on txd
module acsc_remote #(
  parameter int BIT = 16
) (
  // clock
  input wire logic pclk,
  // bench commands and results
  input wire logic send,
  input wire logic [7:0] send_char,
  input wire logic stop_bit,
  output logic [7:0] heard,
  output logic heard_done,
  // line
  input wire logic txd_pin,
  output logic rxd_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    rxd_pin = 1'b1;
    heard_done = 1'b0;
  end
  // one frame per send pulse; a zero stop bit with an all-zero character makes a break frame
  always @(posedge pclk)
    if (send)
    begin
      for (int i = 0; i < 10; i++)
      begin
        rxd_pin <= i == 0 ? 1'b0 : i == 9 ? stop_bit : send_char[i - 1];
        repeat (BIT) @(posedge pclk);
      end
      rxd_pin <= 1'b1; // mark level once the frame is over
    end
  // centre sampling, half a bit after the falling start edge
  always
  begin
    @(negedge txd_pin);
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge pclk);
      heard[i] = txd_pin;
    end
    repeat (BIT) @(posedge pclk);
    heard_done = ~heard_done;
  end
endmodule
